// ### logic/cprf_regfile.sv
// Purpose: Architectural register file of the processor core
// Assumes: Execution unit on the same clock drives all requests
// Notes:   Reads are combinational except control reads, one cycle
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module cprf_regfile
(
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   // Operand reads
   input  wire logic [3:0]           src_sel_in,
   input  wire cprf_pkg::cprf_size_t src_size_in,
   input  wire logic                 src_to_addr_in,
   output logic [31:0]               src_data_out,
   input  wire logic [3:0]           idx_sel_in,
   output logic [31:0]               idx_data_out,
   input  wire logic [2:0]           quad_hi_sel_in,
   input  wire logic [2:0]           quad_lo_sel_in,
   output logic [63:0]               quad_data_out,
   output logic [7:0]                digit_pair_out,
   // Result writes
   input  wire cprf_pkg::cprf_wr_t   wr_in,
   input  wire cprf_pkg::cprf_wr_t   wr2_in,
   // Flags
   input  wire logic                 flags_we_in,
   input  wire cprf_pkg::cprf_flags_t flags_in,
   output cprf_pkg::cprf_flags_t     flags_out,
   // Status word access
   input  wire logic                 psw_we_in,
   input  wire logic                 psw_flag_only_in,
   input  wire logic [15:0]          psw_wdata_in,
   output logic [15:0]               psw_rdata_out,
   output logic                      priv_viol_out,
   output logic                      super_out,
   output logic [1:0]                trace_out,
   output logic [2:0]                int_mask_out,
   // Control registers
   input  wire logic                 ctl_we_in,
   input  wire logic                 ctl_re_in,
   input  wire logic [1:0]           ctl_sel_in,
   input  wire logic [31:0]          ctl_wdata_in,
   output logic [31:0]               ctl_rdata_out,
   // Program counter
   input  wire logic                 pc_inc_in,
   input  wire logic [2:0]           pc_step_in,
   input  wire logic                 pc_load_in,
   input  wire logic [31:0]          pc_load_val_in,
   output logic [31:0]               pc_out,
   // Vector and address outputs
   input  wire logic [9:0]           vec_disp_in,
   output logic [31:0]               vec_addr_out,
   input  wire logic [31:0]          ref_addr_in,
   input  wire cprf_pkg::cprf_ref_t  ref_kind_in,
   input  wire logic                 ref_write_in,
   output logic [23:0]               ext_addr_out,
   output logic [2:0]                space_code_out
);
   cprf_pkg::cprf_state_t s_r;
   cprf_pkg::cprf_state_t s_nxt;
   logic [31:0]           sp_now;

   // ==========================================================
   // Stack pointer banking
   always_comb
   begin
      sp_now = s_r.psw[cprf_pkg::PSW_SUPER] ? s_r.ssp : s_r.usp;
   end

   function automatic logic [31:0] rd_reg(input logic [3:0] sel,
                                          input logic [31:0] sp);
      logic [31:0] v;
      v = 32'h00000000;
      if (!sel[3])
         v = s_r.dreg[sel[2:0]];
      else if (sel[2:0] == 3'h7)
         v = sp;
      else
         v = s_r.areg[sel[2:0]];
      return v;
   endfunction

   // ==========================================================
   // Operand reads
   always_comb
   begin
      logic [31:0] raw;
      raw = rd_reg(src_sel_in, sp_now);
      unique case (src_size_in)
         cprf_pkg::SZ_BYTE:
            src_data_out = {24'h000000, raw[7:0]};
         cprf_pkg::SZ_WORD:
            if (src_to_addr_in)
               src_data_out = {{16{raw[15]}}, raw[15:0]};
            else
               src_data_out = {16'h0000, raw[15:0]};
         default:
            src_data_out = raw;
      endcase
      idx_data_out  = rd_reg(idx_sel_in, sp_now);
      quad_data_out = {s_r.dreg[quad_hi_sel_in],
                       s_r.dreg[quad_lo_sel_in]};
      // High nibble is most significant digit
      digit_pair_out = {raw[7:4], raw[3:0]};
   end

   // ==========================================================
   // Next state
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input cprf_pkg::cprf_wr_t w);
      logic [31:0] v;
      v = old;
      if (!w.sel[3])
      begin
         unique case (w.size)
            cprf_pkg::SZ_BYTE: v = {old[31:8], w.data[7:0]};
            cprf_pkg::SZ_WORD: v = {old[31:16], w.data[15:0]};
            default:           v = w.data;
         endcase
      end
      else if (w.size == cprf_pkg::SZ_WORD)
         v = {{16{w.data[15]}}, w.data[15:0]};
      else
         v = w.data;
      return v;
   endfunction

   always_comb
   begin
      cprf_pkg::cprf_wr_t w;
      logic [15:0] pw;
      s_nxt    = s_r;
      w        = '0;
      pw       = 16'h0000;
      s_nxt.rd = s_r.rd;
      for (int k = 0; k < 2; k++)
      begin
         w = (k == 0) ? wr_in : wr2_in;
         if (w.en)
         begin
            if (!w.sel[3])
               s_nxt.dreg[w.sel[2:0]] = merge(s_nxt.dreg[w.sel[2:0]], w);
            else if (w.sel[2:0] != 3'h7)
               s_nxt.areg[w.sel[2:0]] = merge(32'h00000000, w);
            else if (s_r.psw[cprf_pkg::PSW_SUPER])
               s_nxt.ssp = merge(32'h00000000, w);
            else
               s_nxt.usp = merge(32'h00000000, w);
         end
      end
      // Status word: flag byte path ignores upper byte
      if (psw_we_in)
      begin
         if (psw_flag_only_in || !s_r.psw[cprf_pkg::PSW_SUPER])
            pw = {s_r.psw[15:8], psw_wdata_in[7:0]};
         else
            pw = psw_wdata_in;
         s_nxt.psw = pw & cprf_pkg::PSW_IMPL_MASK;
      end
      if (flags_we_in)
      begin
         s_nxt.psw[cprf_pkg::PSW_X] = flags_in.x;
         s_nxt.psw[cprf_pkg::PSW_N] = flags_in.n;
         s_nxt.psw[cprf_pkg::PSW_Z] = flags_in.z;
         s_nxt.psw[cprf_pkg::PSW_V] = flags_in.v;
         s_nxt.psw[cprf_pkg::PSW_C] = flags_in.c;
      end
      // Control registers, supervisor only
      if (ctl_we_in && s_r.psw[cprf_pkg::PSW_SUPER])
      begin
         unique case (ctl_sel_in)
            cprf_pkg::CSEL_VBASE: s_nxt.vbase = ctl_wdata_in;
            cprf_pkg::CSEL_SRC: s_nxt.source_space_code = ctl_wdata_in[2:0];
            cprf_pkg::CSEL_DST: s_nxt.dfc = ctl_wdata_in[2:0];
            default: ;
         endcase
      end
      if (ctl_re_in)
      begin
         if (!s_r.psw[cprf_pkg::PSW_SUPER])
            s_nxt.rd = 32'h00000000;
         else
            unique case (ctl_sel_in)
               cprf_pkg::CSEL_VBASE: s_nxt.rd = s_r.vbase;
               cprf_pkg::CSEL_SRC: s_nxt.rd = {29'h0, s_r.source_space_code};
               cprf_pkg::CSEL_DST: s_nxt.rd = {29'h0, s_r.dfc};
               default:            s_nxt.rd = 32'h00000000;
            endcase
      end
      // Program counter: load wins over advance
      if (pc_load_in)
         s_nxt.pc = pc_load_val_in;
      else if (pc_inc_in)
         s_nxt.pc = s_r.pc + {29'h0, pc_step_in};
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_r      <= '0;
         s_r.psw  <= cprf_pkg::PSW_RESET;
         s_r.pc   <= cprf_pkg::PC_RESET;
         s_r.vbase <= cprf_pkg::VBASE_RESET;
         s_r.source_space_code  <= cprf_pkg::SPACE_RESET;
         s_r.dfc  <= cprf_pkg::SPACE_RESET;
      end
      else
         s_r <= s_nxt;
   end

   // ==========================================================
   // Outputs
   always_comb
   begin
      flags_out = '{x: s_r.psw[cprf_pkg::PSW_X], n: s_r.psw[cprf_pkg::PSW_N],
                    z: s_r.psw[cprf_pkg::PSW_Z], v: s_r.psw[cprf_pkg::PSW_V],
                    c: s_r.psw[cprf_pkg::PSW_C]};
      if (psw_flag_only_in || !s_r.psw[cprf_pkg::PSW_SUPER])
         psw_rdata_out = s_r.psw & cprf_pkg::PSW_FLAG_MASK;
      else
         psw_rdata_out = s_r.psw;
      priv_viol_out = (psw_we_in || ctl_we_in || ctl_re_in)
                      && !psw_flag_only_in
                      && !s_r.psw[cprf_pkg::PSW_SUPER];
      super_out     = s_r.psw[cprf_pkg::PSW_SUPER];
      trace_out     = {s_r.psw[cprf_pkg::PSW_TRACE_HI],
                       s_r.psw[cprf_pkg::PSW_TRACE_LO]};
      int_mask_out  = s_r.psw[cprf_pkg::PSW_MASK_MSB:
                              cprf_pkg::PSW_MASK_LSB];
      ctl_rdata_out = s_r.rd;
      pc_out        = s_r.pc;
      vec_addr_out  = s_r.vbase + {22'h0, vec_disp_in};
      ext_addr_out  = ref_addr_in[23:0];
      unique case (ref_kind_in)
         cprf_pkg::REF_CPU:
            space_code_out = cprf_pkg::FC_CPU_SPACE;
         cprf_pkg::REF_ALT_SRC:
            space_code_out = ref_write_in ? s_r.dfc : s_r.source_space_code;
         cprf_pkg::REF_PROG:
            space_code_out = s_r.psw[cprf_pkg::PSW_SUPER] ?
                             cprf_pkg::FC_SUPER_PROG :
                             cprf_pkg::FC_USER_PROG;
         default:
            space_code_out = s_r.psw[cprf_pkg::PSW_SUPER] ?
                             cprf_pkg::FC_SUPER_DATA :
                             cprf_pkg::FC_USER_DATA;
      endcase
   end

   // ==========================================================
   // Checks
   property p_byte_keeps_upper;
      @(posedge clk_in) disable iff (rst_in)
      (wr_in.en && !wr_in.sel[3] && wr_in.size == cprf_pkg::SZ_BYTE
       && !wr2_in.en)
      |=> s_r.dreg[$past(wr_in.sel[2:0])][31:8]
          == $past(s_r.dreg[wr_in.sel[2:0]][31:8]);
   endproperty
   a_byte_keeps_upper: assert property (p_byte_keeps_upper)
      else $error("byte write changed upper data bits");

   property p_addr_sign_ext;
      @(posedge clk_in) disable iff (rst_in)
      (wr_in.en && wr_in.sel[3] && wr_in.sel[2:0] != 3'h7
       && wr_in.size == cprf_pkg::SZ_WORD && !wr2_in.en)
      |=> s_r.areg[$past(wr_in.sel[2:0])]
          == {{16{$past(wr_in.data[15])}}, $past(wr_in.data[15:0])};
   endproperty
   a_addr_sign_ext: assert property (p_addr_sign_ext)
      else $error("address word write not sign extended");

   property p_stack_bank;
      @(posedge clk_in) disable iff (rst_in)
      (idx_sel_in == 4'hF) |->
      idx_data_out == (super_out ? s_r.ssp : s_r.usp);
   endproperty
   a_stack_bank: assert property (p_stack_bank)
      else $error("stack pointer bank wrong");

   property p_psw_zero_bits;
      @(posedge clk_in) disable iff (rst_in)
      1'b1 |=> (s_r.psw & ~cprf_pkg::PSW_IMPL_MASK) == 16'h0000;
   endproperty
   a_psw_zero_bits: assert property (p_psw_zero_bits)
      else $error("unimplemented status bit set");

   property p_user_psw_read;
      @(posedge clk_in) disable iff (rst_in)
      !super_out |-> psw_rdata_out[15:8] == 8'h00;
   endproperty
   a_user_psw_read: assert property (p_user_psw_read)
      else $error("user read sees system byte");

   property p_flags_update;
      @(posedge clk_in) disable iff (rst_in)
      (flags_we_in && !psw_we_in) |=> flags_out == $past(flags_in);
   endproperty
   a_flags_update: assert property (p_flags_update)
      else $error("flags did not follow result");

   property p_space_reg_width;
      @(posedge clk_in) disable iff (rst_in)
      ctl_re_in ##1 1'b1 |-> ctl_rdata_out[31:3] == 29'h0
                              || $past(ctl_sel_in) == cprf_pkg::CSEL_VBASE;
   endproperty
   a_space_reg_width: assert property (p_space_reg_width)
      else $error("space register upper bits nonzero");

   property p_pc_advance;
      @(posedge clk_in) disable iff (rst_in)
      (pc_inc_in && !pc_load_in) |=>
      pc_out == $past(pc_out) + {29'h0, $past(pc_step_in)};
   endproperty
   a_pc_advance: assert property (p_pc_advance)
      else $error("program counter did not advance");

   property p_alt_space;
      @(posedge clk_in) disable iff (rst_in)
      (ref_kind_in == cprf_pkg::REF_ALT_SRC && !ref_write_in)
      |-> space_code_out == s_r.source_space_code;
   endproperty
   a_alt_space: assert property (p_alt_space)
      else $error("alternate move used wrong space");
endmodule // cprf_regfile

// ### pkg/cprf_pkg.sv
// Purpose: Constants and types for the processor register file
// Assumes: Single processor clock, execution unit on the port side
// Notes:   Control register selectors are local codes of this block
package cprf_pkg;
   // ==========================================================
   // Widths
   localparam int XLEN      = 32;
   localparam int EXT_ALEN  = 24;
   localparam int SPACE_W   = 3;
   localparam int PSW_W     = 16;
   // ==========================================================
   // Status word field positions
   localparam int PSW_TRACE_HI  = 15;
   localparam int PSW_TRACE_LO  = 14;
   localparam int PSW_SUPER     = 13;
   localparam int PSW_MASK_MSB  = 10;
   localparam int PSW_MASK_LSB  = 8;
   localparam int PSW_X         = 4;
   localparam int PSW_N         = 3;
   localparam int PSW_Z         = 2;
   localparam int PSW_V         = 1;
   localparam int PSW_C         = 0;
   // Implemented bits: 15..13, 10..8, 4..0
   localparam logic [15:0] PSW_IMPL_MASK = 16'hE71F;
   localparam logic [15:0] PSW_FLAG_MASK = 16'h001F;
   // ==========================================================
   // Reset values
   localparam logic [15:0] PSW_RESET  = 16'h2700;
   localparam logic [31:0] PC_RESET   = 32'h00000000;
   localparam logic [31:0] VBASE_RESET = 32'h00000000;
   localparam logic [2:0]  SPACE_RESET = 3'h0;
   // ==========================================================
   // Space codes driven with each reference
   localparam logic [2:0] FC_USER_DATA  = 3'h1;
   localparam logic [2:0] FC_USER_PROG  = 3'h2;
   localparam logic [2:0] FC_SUPER_DATA = 3'h5;
   localparam logic [2:0] FC_SUPER_PROG = 3'h6;
   localparam logic [2:0] FC_CPU_SPACE  = 3'h7;
   // ==========================================================
   // Control register selectors
   localparam logic [1:0] CSEL_VBASE = 2'h0;
   localparam logic [1:0] CSEL_SRC = 2'h1;
   localparam logic [1:0] CSEL_DST = 2'h2;

   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cprf_size_t;
   typedef enum logic [1:0] {
      REF_DATA, REF_PROG, REF_CPU, REF_ALT_SRC
   } cprf_ref_t;

   // Register write request from execution
   typedef struct packed {
      logic          en;
      logic [3:0]    sel;     // 0..7 data, 8..15 address
      cprf_size_t    size;
      logic [31:0]   data;
   } cprf_wr_t;

   // Condition flags from an operation result
   typedef struct packed {
      logic x;
      logic n;
      logic z;
      logic v;
      logic c;
   } cprf_flags_t;

   // Complete architectural state
   typedef struct packed {
      logic [7:0][31:0] dreg;
      logic [6:0][31:0] areg;
      logic [31:0]      usp;
      logic [31:0]      ssp;
      logic [31:0]      pc;
      logic [15:0]      psw;
      logic [31:0]      vbase;
      logic [2:0]       source_space_code;
      logic [2:0]       dfc;
      logic [31:0]      rd;
   } cprf_state_t;
endpackage

// ### verification/cprf_exec_model.sv
// Purpose: Execution unit model issuing register file requests
// Assumes: Requests launch just after a rising clock edge
// Notes:   Each strobe stands for exactly one taking edge
`timescale 1ns/1ps
module cprf_exec_model
(
   // Clock
   input  wire logic clk_in
);
   // ==========================================================
   // Request lines, idle at time zero
   logic [3:0]            src_sel = '0;
   cprf_pkg::cprf_size_t  src_size = cprf_pkg::SZ_LONG;
   logic                  src_to_addr = 1'b0;
   logic [3:0]            idx_sel = '0;
   logic [2:0]            quad_hi = '0;
   logic [2:0]            quad_lo = '0;
   cprf_pkg::cprf_wr_t    wr = '0;
   cprf_pkg::cprf_wr_t    wr2 = '0;
   logic                  flags_we = 1'b0;
   cprf_pkg::cprf_flags_t flags = '0;
   logic                  psw_we = 1'b0;
   logic                  psw_fo = 1'b0;
   logic [15:0]           psw_wd = '0;
   logic                  ctl_we = 1'b0;
   logic                  ctl_re = 1'b0;
   logic [1:0]            ctl_sel = '0;
   logic [31:0]           ctl_wd = '0;
   logic                  pc_inc = 1'b0;
   logic [2:0]            pc_step = '0;
   logic                  pc_load = 1'b0;
   logic [31:0]           pc_val = '0;
   logic [9:0]            vec_disp = '0;
   logic [31:0]           ref_addr = '0;
   cprf_pkg::cprf_ref_t   ref_kind = cprf_pkg::REF_DATA;
   logic                  ref_write = 1'b0;
   // ==========================================================
   // Request tasks
   task automatic wreg(input logic [3:0] s, input cprf_pkg::cprf_size_t z,
                       input logic [31:0] d);
      @(posedge clk_in);
      wr <= '{1'b1, s, z, d};
      @(posedge clk_in);
      wr.en <= 1'b0;
   endtask
   task automatic wpsw(input logic [15:0] d, input logic f);
      @(posedge clk_in);
      psw_we <= 1'b1;
      psw_wd <= d;
      psw_fo <= f;
      @(posedge clk_in);
      psw_we <= 1'b0;
   endtask
   task automatic wflg(input cprf_pkg::cprf_flags_t f);
      @(posedge clk_in);
      flags_we <= 1'b1;
      flags <= f;
      @(posedge clk_in);
      flags_we <= 1'b0;
   endtask
   task automatic wctl(input logic [1:0] s, input logic [31:0] d);
      @(posedge clk_in);
      ctl_we <= 1'b1;
      ctl_sel <= s;
      ctl_wd <= d;
      @(posedge clk_in);
      ctl_we <= 1'b0;
   endtask
   task automatic rctl(input logic [1:0] s);
      @(posedge clk_in);
      ctl_re <= 1'b1;
      ctl_sel <= s;
      @(posedge clk_in);
      ctl_re <= 1'b0;
   endtask
   task automatic pcop(input logic i, input logic [2:0] st, input logic l,
                       input logic [31:0] v);
      @(posedge clk_in);
      pc_inc <= i;
      pc_step <= st;
      pc_load <= l;
      pc_val <= v;
      @(posedge clk_in);
      pc_inc <= 1'b0;
      pc_load <= 1'b0;
   endtask
endmodule // cprf_exec_model

// ### verification/cprf_regfile_tb.sv
// Purpose: Self-checking bench for the processor register file
// Assumes: Execution unit model tasks drive writes, status, flags, control and counter; the bench drives reads and references
// Notes:   Expected values queue up; a monitor compares at falling edge
`timescale 1ns/1ps
module cprf_regfile_tb;
   // ==========================================================
   // Clock, reset and bookkeeping
   typedef struct packed {logic [3:0] k; logic [63:0] e;} cprf_note_t;
   logic                  clk_in = 1'b0;
   logic                  rst_in = 1'b1;
   int                    failures = 0;
   int                    n_compared = 0;
   logic [31:0]           lfsr_r = 32'hE05D;
   cprf_note_t            q [$];
   string nm [13] = '{"src", "idx", "quad", "digit", "flags", "psw",
      "viol", "ctl", "pc", "vec", "ext", "space", "mode"};
   logic [31:0]           src_d, idx_d, ctl_d, pc_d, vec_d;
   logic [63:0]           quad_d;
   logic [7:0]            dig_d;
   logic [15:0]           psw_d;
   cprf_pkg::cprf_flags_t flg_d;
   logic                  viol_d, sup_d;
   logic [1:0]            trc_d;
   logic [2:0]            msk_d, fc_d;
   logic [23:0]           ext_d;
   initial
   begin
      forever #2.5 clk_in = ~clk_in;
   end
   // ==========================================================
   // Model and design
   cprf_exec_model u (.clk_in(clk_in));
   cprf_regfile dut
   (
      .clk_in(clk_in), .rst_in(rst_in),
      .src_sel_in(u.src_sel), .src_size_in(u.src_size),
      .src_to_addr_in(u.src_to_addr), .src_data_out(src_d),
      .idx_sel_in(u.idx_sel), .idx_data_out(idx_d),
      .quad_hi_sel_in(u.quad_hi), .quad_lo_sel_in(u.quad_lo),
      .quad_data_out(quad_d), .digit_pair_out(dig_d),
      .wr_in(u.wr), .wr2_in(u.wr2),
      .flags_we_in(u.flags_we), .flags_in(u.flags), .flags_out(flg_d),
      .psw_we_in(u.psw_we), .psw_flag_only_in(u.psw_fo),
      .psw_wdata_in(u.psw_wd), .psw_rdata_out(psw_d),
      .priv_viol_out(viol_d), .super_out(sup_d),
      .trace_out(trc_d), .int_mask_out(msk_d),
      .ctl_we_in(u.ctl_we), .ctl_re_in(u.ctl_re),
      .ctl_sel_in(u.ctl_sel), .ctl_wdata_in(u.ctl_wd),
      .ctl_rdata_out(ctl_d),
      .pc_inc_in(u.pc_inc), .pc_step_in(u.pc_step),
      .pc_load_in(u.pc_load), .pc_load_val_in(u.pc_val), .pc_out(pc_d),
      .vec_disp_in(u.vec_disp), .vec_addr_out(vec_d),
      .ref_addr_in(u.ref_addr), .ref_kind_in(u.ref_kind),
      .ref_write_in(u.ref_write), .ext_addr_out(ext_d),
      .space_code_out(fc_d)
   );
   // ==========================================================
   // Expectation queue and monitor
   function automatic logic [31:0] rnd();
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      return lfsr_r;
   endfunction
   function automatic logic [63:0] seen(input logic [3:0] k);
      case (k)
         4'h0: return {32'h0, src_d};
         4'h1: return {32'h0, idx_d};
         4'h2: return quad_d;
         4'h3: return {56'h0, dig_d};
         4'h4: return {59'h0, flg_d};
         4'h5: return {48'h0, psw_d};
         4'h6: return {63'h0, viol_d};
         4'h7: return {32'h0, ctl_d};
         4'h8: return {32'h0, pc_d};
         4'h9: return {32'h0, vec_d};
         4'hA: return {40'h0, ext_d};
         4'hB: return {61'h0, fc_d};
         default: return {58'h0, sup_d, trc_d, msk_d};
      endcase
   endfunction
   task automatic note(input logic [3:0] k, input logic [63:0] e);
      q.push_back('{k, e});
   endtask
   task automatic cmp(input logic [3:0] k, input logic [63:0] e);
      n_compared++;
      if (seen(k) !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm[k], e, seen(k));
      end
   endtask
   always @(negedge clk_in)
   begin
      while (q.size() > 0)
      begin
         cmp(q[0].k, q[0].e);
         void'(q.pop_front());
      end
   end
   // ==========================================================
   // Read helpers
   task automatic rsrc(input logic [3:0] s, input cprf_pkg::cprf_size_t z,
                       input logic a, input logic [31:0] e);
      @(posedge clk_in);
      u.src_sel <= s;
      u.src_size <= z;
      u.src_to_addr <= a;
      note(4'h0, {32'h0, e});
   endtask
   task automatic ridx(input logic [3:0] s, input logic [31:0] e);
      @(posedge clk_in);
      u.idx_sel <= s;
      note(4'h1, {32'h0, e});
   endtask
   task automatic refc(input logic [31:0] a, input cprf_pkg::cprf_ref_t k,
                       input logic w, input logic [2:0] e);
      @(posedge clk_in);
      u.ref_addr <= a;
      u.ref_kind <= k;
      u.ref_write <= w;
      note(4'hB, {61'h0, e});
      note(4'hA, {40'h0, a[23:0]});
   endtask
   task automatic done(input string n);
      $display("test %s done", n);
   endtask
   task automatic report_and_stop();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #20000;
      failures++;
      report_and_stop();
   end
   // ==========================================================
   // Scenarios
   initial
   begin
      logic [31:0] r;
      logic [31:0] v [16];
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      note(4'h5, 64'h2700);
      note(4'hC, 64'h27);
      done("reset");
      r = rnd();
      u.wreg(4'h3, cprf_pkg::SZ_LONG, r);
      u.wreg(4'h3, cprf_pkg::SZ_BYTE, 32'hFFFFFFA5);
      rsrc(4'h3, cprf_pkg::SZ_LONG, 1'b0, {r[31:8], 8'hA5});
      u.wreg(4'h3, cprf_pkg::SZ_WORD, 32'h0000BEEF);
      rsrc(4'h3, cprf_pkg::SZ_LONG, 1'b0, {r[31:16], 16'hBEEF});
      rsrc(4'h3, cprf_pkg::SZ_BYTE, 1'b0, 32'hEF);
      note(4'h3, 64'hEF);
      rsrc(4'h3, cprf_pkg::SZ_WORD, 1'b1, 32'hFFFFBEEF);
      u.wreg(4'h8, cprf_pkg::SZ_WORD, 32'h00008000);
      rsrc(4'h8, cprf_pkg::SZ_LONG, 1'b0, 32'hFFFF8000);
      rsrc(4'h8, cprf_pkg::SZ_WORD, 1'b0, 32'h8000);
      u.wreg(4'h9, cprf_pkg::SZ_WORD, 32'h12347654);
      rsrc(4'h9, cprf_pkg::SZ_LONG, 1'b0, 32'h00007654);
      done("sizes");
      for (int i = 0; i < 16; i++)
      begin
         v[i] = rnd();
         u.wreg(i[3:0], cprf_pkg::SZ_LONG, v[i]);
      end
      for (int i = 0; i < 16; i++)
         ridx(i[3:0], v[i]);
      @(posedge clk_in);
      u.quad_hi <= 3'h5;
      u.quad_lo <= 3'h2;
      note(4'h2, {v[5], v[2]});
      done("index");
      u.wflg(5'h15);
      note(4'h4, 64'h15);
      note(4'h5, 64'h2715);
      u.wpsw(16'hFFFF, 1'b0);
      note(4'h5, 64'hE71F);
      note(4'hC, 64'h3F);
      u.wpsw(16'h2000, 1'b0);
      u.wpsw(16'hFF0A, 1'b1);
      note(4'h5, 64'h000A);
      @(posedge clk_in);
      u.psw_fo <= 1'b0;
      note(4'h5, 64'h200A);
      done("status");
      u.wctl(cprf_pkg::CSEL_SRC, 32'hFFFFFFFF);
      u.rctl(cprf_pkg::CSEL_SRC);
      note(4'h7, 64'h7);
      u.wctl(cprf_pkg::CSEL_DST, 32'h0000000D);
      u.rctl(cprf_pkg::CSEL_DST);
      note(4'h7, 64'h5);
      r = rnd();
      u.wctl(cprf_pkg::CSEL_VBASE, r);
      u.rctl(cprf_pkg::CSEL_VBASE);
      note(4'h7, {32'h0, r});
      @(posedge clk_in);
      u.vec_disp <= 10'h3FC;
      note(4'h9, {32'h0, r + 32'h000003FC});
      r = rnd();
      refc(r, cprf_pkg::REF_DATA, 1'b0, cprf_pkg::FC_SUPER_DATA);
      refc(r, cprf_pkg::REF_PROG, 1'b0, cprf_pkg::FC_SUPER_PROG);
      refc(r, cprf_pkg::REF_CPU, 1'b0, cprf_pkg::FC_CPU_SPACE);
      refc(r, cprf_pkg::REF_ALT_SRC, 1'b0, 3'h7);
      refc(r, cprf_pkg::REF_ALT_SRC, 1'b1, 3'h5);
      done("control");
      u.pcop(1'b0, 3'h0, 1'b1, 32'h00001000);
      note(4'h8, 64'h1000);
      u.pcop(1'b1, 3'h4, 1'b0, 32'h00000000);
      note(4'h8, 64'h1004);
      u.pcop(1'b1, 3'h2, 1'b1, 32'h00002000);
      note(4'h8, 64'h2000);
      done("counter");
      u.wpsw(16'h0000, 1'b0);
      note(4'hC, 64'h0);
      ridx(4'hF, 32'h0);
      u.wreg(4'hF, cprf_pkg::SZ_LONG, ~v[15]);
      ridx(4'hF, ~v[15]);
      u.wpsw(16'hA71B, 1'b0);
      note(4'h5, 64'h001B);
      refc(r, cprf_pkg::REF_DATA, 1'b0, cprf_pkg::FC_USER_DATA);
      refc(r, cprf_pkg::REF_PROG, 1'b0, cprf_pkg::FC_USER_PROG);
      @(posedge clk_in);
      u.ctl_re <= 1'b1;
      u.ctl_sel <= cprf_pkg::CSEL_SRC;
      note(4'h6, 64'h1);
      @(posedge clk_in);
      u.ctl_re <= 1'b0;
      note(4'h7, 64'h0);
      done("user");
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      note(4'h5, 64'h2700);
      note(4'h8, 64'h0);
      done("rereset");
      repeat (2) @(posedge clk_in);
      report_and_stop();
   end
endmodule // cprf_regfile_tb
